// ==== src/cpmc_top.sv ====
// clock source selection and operating mode control with axi4-lite registers
`timescale 1ns/10ps

// Functional notes
// - slow mode instruction rate is the low rc clock divided by four.
// - low rc stops only in power-down, or green with 32k type and no watchdog.
// - no separate control switches off the low rc oscillator.
// - high clock type option sets crystal drive: 12m, 4m or 32k.
// - rc type takes rc or external clock on input pin; output pin becomes gpio.
// - reset holds until selected high oscillator has started; rc short, crystal long.
// - low rc clocks the watchdog and, when speed select is 1, the system.
// - four modes: normal, slow, power-down and green, chosen by software.
// - power-down resumes only on wakeup pin or reset, then enters normal mode.
// - green without timer 0 wakeup resumes on pin or reset to previous mode.
// - green also wakes on timer 0 overflow when its run enable is set.
// - watchdog runs by its option alone, in every mode but power-down, where the stopped low rc gives it no ticks.
// - cpu mode field: 00 normal, 01 power-down, 10 green, 11 reserved.
// - speed select 0 picks high clock, 1 picks internal low clock.
// - stop bit 1 halts the high oscillator, low rc keeps running.
// - wake from power-down waits 2048 high oscillator clocks, then normal.
module cpmc_top (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        hosc_clk_pin,
  input  wire logic        lrc_clk_pin,
  input  wire logic        wake_pin,
  input  wire logic        timer0_overflow,
  input  wire logic        timer0_run_enable,
  input  wire logic        timer1_run_enable,
  output logic             hosc_enable,
  output logic             lrc_enable,
  output logic [1:0]       xtal_drive,
  output logic             osc_out_gpio,
  output logic             sysclk_low_sel,
  output logic             cpu_cycle_en,
  output logic             cpu_exec_en,
  output logic             timer0_tick_en,
  output logic             timer1_tick_en,
  output logic             watchdog_run,
  output logic             watchdog_clk_en,
  output logic             irq_accept,
  output logic             reset_hold
);

  // **********
  // state and registers
  // **********
  cpmc_pkg::cpmc_state_t state_q;
  cpmc_pkg::cpmc_state_t state_d;
  cpmc_pkg::cpmc_ctrl_t  ctrl_q;
  cpmc_pkg::cpmc_ctrl_t  ctrl_d;
  cpmc_pkg::cpmc_opt_t   opt_q;
  cpmc_pkg::cpmc_opt_t   opt_d;
  logic [1:0]            div_q;
  logic                  aw_q;
  logic                  w_q;
  logic [11:0]           awaddr_q;
  logic [31:0]           wdata_q;
  logic                  wstrb0_q;
  logic                  bvalid_q;
  logic [1:0]            bresp_q;
  logic                  rvalid_q;
  logic [1:0]            rresp_q;
  logic [31:0]           rdata_q;

  // **********
  // pin synchronisers and warmup counter
  // **********
  logic        hosc_rise;
  logic        lrc_rise;
  logic        wake_change;
  logic        warm_start;
  logic        warm_done;
  logic        warm_busy;
  logic [11:0] warm_target;
  logic [11:0] boot_target;

  cpmc_pin_sync u_hosc_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin_in  (hosc_clk_pin),
    .level   (),
    .rise    (hosc_rise),
    .change  ()
  );

  cpmc_pin_sync u_lrc_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin_in  (lrc_clk_pin),
    .level   (),
    .rise    (lrc_rise),
    .change  ()
  );

  cpmc_pin_sync u_wake_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin_in  (wake_pin),
    .level   (),
    .rise    (),
    .change  (wake_change)
  );

  // rc start-up is short, crystal start-up long
  assign boot_target = (opt_q.hclk_type == cpmc_pkg::CPMC_HCLK_RC) ?
                       cpmc_pkg::CPMC_RC_START : cpmc_pkg::CPMC_XTAL_START;
  assign warm_target = (state_q == cpmc_pkg::CPMC_ST_BOOT) ?
                       boot_target : cpmc_pkg::CPMC_WAKE_CLKS;

  cpmc_warmup u_warmup (
    .clk_sys (clk_sys),
    .rst     (rst),
    .start   (warm_start),
    .tick    (hosc_rise),
    .target  (warm_target),
    .busy    (warm_busy),
    .done    (warm_done)
  );

  // **********
  // mode decode
  // **********
  logic st_run;
  logic st_green;
  logic st_sleep;
  logic st_wake;
  logic st_boot;
  logic is_32k;
  logic green_wake;
  logic sleep_wake;
  logic ovf_wake;

  assign st_run     = (state_q == cpmc_pkg::CPMC_ST_RUN);
  assign st_green   = (state_q == cpmc_pkg::CPMC_ST_GREEN);
  assign st_sleep   = (state_q == cpmc_pkg::CPMC_ST_SLEEP);
  assign st_wake    = (state_q == cpmc_pkg::CPMC_ST_WAKE);
  assign st_boot    = (state_q == cpmc_pkg::CPMC_ST_BOOT);
  assign is_32k     = (opt_q.hclk_type == cpmc_pkg::CPMC_HCLK_32K);
  assign ovf_wake   = timer0_overflow & timer0_run_enable;
  assign green_wake = st_green & (wake_change | ovf_wake);
  assign sleep_wake = st_sleep & wake_change;
  assign warm_start = sleep_wake;

  // **********
  // operating mode state machine
  // **********
  always_comb begin
    state_d = state_q;
    case (state_q)
      cpmc_pkg::CPMC_ST_BOOT: begin
        if (warm_done) begin
          state_d = cpmc_pkg::CPMC_ST_RUN;
        end
      end
      cpmc_pkg::CPMC_ST_RUN: begin
        if (ctrl_q.cpu_mode_field == cpmc_pkg::CPMC_MODE_SLEEP) begin
          state_d = cpmc_pkg::CPMC_ST_SLEEP;
        end else if (ctrl_q.cpu_mode_field == cpmc_pkg::CPMC_MODE_GREEN) begin
          state_d = cpmc_pkg::CPMC_ST_GREEN;
        end
      end
      cpmc_pkg::CPMC_ST_GREEN: begin
        if (green_wake) begin
          state_d = cpmc_pkg::CPMC_ST_RUN;
        end
      end
      cpmc_pkg::CPMC_ST_SLEEP: begin
        if (sleep_wake) begin
          state_d = cpmc_pkg::CPMC_ST_WAKE;
        end
      end
      cpmc_pkg::CPMC_ST_WAKE: begin
        if (warm_done) begin
          state_d = cpmc_pkg::CPMC_ST_RUN;
        end
      end
      default: begin
        state_d = cpmc_pkg::CPMC_ST_BOOT;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= cpmc_pkg::CPMC_ST_BOOT;
    end else begin
      state_q <= state_d;
    end
  end

  // **********
  // axi4-lite write channel
  // **********
  logic wr_fire;
  logic wr_ctrl;
  logic wr_opt;
  logic wr_hit;

  assign s_axi_awready = ~aw_q & ~bvalid_q;
  assign s_axi_wready  = ~w_q & ~bvalid_q;
  assign wr_fire       = aw_q & w_q;
  assign wr_ctrl       = wr_fire & wstrb0_q & (awaddr_q == cpmc_pkg::CPMC_CTRL_ADDR);
  assign wr_opt        = wr_fire & wstrb0_q & (awaddr_q == cpmc_pkg::CPMC_OPT_ADDR);
  assign wr_hit        = (awaddr_q == cpmc_pkg::CPMC_CTRL_ADDR) |
                         (awaddr_q == cpmc_pkg::CPMC_OPT_ADDR) |
                         (awaddr_q == cpmc_pkg::CPMC_STAT_ADDR);
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aw_q     <= 1'h0;
      w_q      <= 1'h0;
      awaddr_q <= 12'h000;
      wdata_q  <= 32'h0000_0000;
      wstrb0_q <= 1'h0;
      bvalid_q <= 1'h0;
      bresp_q  <= cpmc_pkg::CPMC_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q     <= 1'h1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q      <= 1'h1;
        wdata_q  <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_q     <= 1'h0;
        w_q      <= 1'h0;
        bvalid_q <= 1'h1;
        bresp_q  <= wr_hit ? cpmc_pkg::CPMC_OKAY : cpmc_pkg::CPMC_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'h0;
      end
    end
  end

  // **********
  // oscillator mode and option registers
  // **********
  always_comb begin
    ctrl_d = ctrl_q;
    opt_d  = opt_q;
    if (wr_ctrl) begin
      ctrl_d.high_osc_stop      = wdata_q[cpmc_pkg::CPMC_HSTOP_BIT];
      ctrl_d.clock_speed_select = wdata_q[cpmc_pkg::CPMC_SPEED_BIT];
      ctrl_d.cpu_mode_field     = wdata_q[cpmc_pkg::CPMC_MODE_LSB +: 2];
    end
    if (wr_opt) begin
      opt_d.hclk_type  = wdata_q[cpmc_pkg::CPMC_HTYPE_LSB +: 2];
      opt_d.wdt_enable = wdata_q[cpmc_pkg::CPMC_WDT_BIT];
    end
    // wakeup returns the field to normal; hardware wins over a write
    if (green_wake) begin
      ctrl_d.cpu_mode_field = cpmc_pkg::CPMC_MODE_NORMAL;
    end
    if (sleep_wake) begin
      ctrl_d.cpu_mode_field     = cpmc_pkg::CPMC_MODE_NORMAL;
      ctrl_d.clock_speed_select = 1'h0;
      ctrl_d.high_osc_stop      = 1'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_q <= '0;
      opt_q  <= {cpmc_pkg::CPMC_WDT_RST, cpmc_pkg::CPMC_HTYPE_RST};
    end else begin
      ctrl_q <= ctrl_d;
      opt_q  <= opt_d;
    end
  end

  // **********
  // axi4-lite read channel
  // **********
  logic        rd_fire;
  logic [31:0] rd_mux;
  logic        rd_hit;
  logic [31:0] stat_word;
  logic [31:0] ctrl_word;
  logic [31:0] opt_word;

  assign s_axi_arready = ~rvalid_q;
  assign rd_fire       = s_axi_arvalid & ~rvalid_q;
  assign ctrl_word     = {27'h0000000, ctrl_q, 1'h0};
  assign opt_word      = {29'h00000000, opt_q};
  assign stat_word     = {24'h000000, reset_hold, 1'h0, hosc_enable, lrc_enable, st_run, state_q};
  assign rd_hit        = (s_axi_araddr == cpmc_pkg::CPMC_CTRL_ADDR) |
                         (s_axi_araddr == cpmc_pkg::CPMC_OPT_ADDR) |
                         (s_axi_araddr == cpmc_pkg::CPMC_STAT_ADDR);
  assign rd_mux        = (s_axi_araddr == cpmc_pkg::CPMC_CTRL_ADDR) ? ctrl_word :
                         (s_axi_araddr == cpmc_pkg::CPMC_OPT_ADDR)  ? opt_word  :
                         (s_axi_araddr == cpmc_pkg::CPMC_STAT_ADDR) ? stat_word :
                         32'h0000_0000;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rvalid_q <= 1'h0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= cpmc_pkg::CPMC_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'h1;
      rdata_q  <= rd_mux;
      rresp_q  <= rd_hit ? cpmc_pkg::CPMC_OKAY : cpmc_pkg::CPMC_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'h0;
    end
  end

  // **********
  // slow mode divider
  // **********
  logic slow_tick;
  logic clk_live;

  assign slow_tick = lrc_rise & (div_q == cpmc_pkg::CPMC_SLOW_LAST);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_q <= 2'h0;
    end else if (lrc_rise) begin
      div_q <= div_q + 2'h1;
    end
  end

  // **********
  // oscillator, clock and execution outputs
  // **********
  // low rc has no enable of its own: only mode and options gate it
  assign lrc_enable      = ~st_sleep & ~(st_green & is_32k & ~opt_q.wdt_enable);
  assign hosc_enable     = st_boot | st_wake |
                           ((st_run | st_green) & ~ctrl_q.high_osc_stop);
  assign xtal_drive      = opt_q.hclk_type;
  assign osc_out_gpio    = (opt_q.hclk_type == cpmc_pkg::CPMC_HCLK_RC);
  assign sysclk_low_sel  = ctrl_q.clock_speed_select;
  assign clk_live        = st_run | st_green;
  assign cpu_cycle_en    = clk_live & (ctrl_q.clock_speed_select ? slow_tick : hosc_rise);
  assign cpu_exec_en     = cpu_cycle_en & st_run;
  assign timer0_tick_en  = cpu_cycle_en & timer0_run_enable;
  assign timer1_tick_en  = cpu_cycle_en & timer1_run_enable;
  assign watchdog_run    = opt_q.wdt_enable;
  assign watchdog_clk_en = opt_q.wdt_enable & lrc_rise;
  assign irq_accept      = clk_live;
  assign reset_hold      = st_boot & warm_busy;

endmodule

// ==== src/cpmc_pkg.sv ====
// package: constants and types for clock and power mode control
package cpmc_pkg;

  // **********
  // register map
  // **********
  localparam logic [7:0]  CPMC_CTRL_IDX  = 8'hCA;
  localparam logic [11:0] CPMC_CTRL_ADDR = {2'h0, CPMC_CTRL_IDX, 2'h0};
  localparam logic [11:0] CPMC_OPT_ADDR  = 12'h400;
  localparam logic [11:0] CPMC_STAT_ADDR = 12'h404;
  localparam int          CPMC_HSTOP_BIT = 1;
  localparam int          CPMC_SPEED_BIT = 2;
  localparam int          CPMC_MODE_LSB  = 3;
  localparam int          CPMC_HTYPE_LSB = 0;
  localparam int          CPMC_WDT_BIT   = 2;
  localparam logic [1:0]  CPMC_OKAY      = 2'h0;
  localparam logic [1:0]  CPMC_SLVERR    = 2'h2;

  // **********
  // encodings
  // **********
  localparam logic [1:0] CPMC_MODE_NORMAL = 2'h0;
  localparam logic [1:0] CPMC_MODE_SLEEP  = 2'h1;
  localparam logic [1:0] CPMC_MODE_GREEN  = 2'h2;
  localparam logic [1:0] CPMC_HCLK_RC     = 2'h0;
  localparam logic [1:0] CPMC_HCLK_32K    = 2'h1;
  localparam logic [1:0] CPMC_HCLK_12M    = 2'h2;
  localparam logic [1:0] CPMC_HCLK_4M     = 2'h3;

  // **********
  // reset values and counts
  // **********
  localparam logic [1:0]  CPMC_HTYPE_RST   = CPMC_HCLK_12M;
  localparam logic        CPMC_WDT_RST     = 1'h1;
  localparam logic [1:0]  CPMC_SLOW_LAST   = 2'h3;
  localparam logic [11:0] CPMC_WAKE_CLKS   = 12'h800;
  localparam logic [11:0] CPMC_RC_START    = 12'h010;
  localparam logic [11:0] CPMC_XTAL_START  = 12'h800;

  typedef enum logic [2:0] {
    CPMC_ST_BOOT  = 3'b000,
    CPMC_ST_RUN   = 3'b001,
    CPMC_ST_GREEN = 3'b010,
    CPMC_ST_SLEEP = 3'b011,
    CPMC_ST_WAKE  = 3'b100
  } cpmc_state_t;

  typedef struct packed {
    logic [1:0] cpu_mode_field;
    logic       clock_speed_select;
    logic       high_osc_stop;
  } cpmc_ctrl_t;

  typedef struct packed {
    logic       wdt_enable;
    logic [1:0] hclk_type;
  } cpmc_opt_t;

endpackage

// ==== src/cpmc_pin_sync.sv ====
// two-stage synchroniser with rise and change pulses
`timescale 1ns/10ps
module cpmc_pin_sync (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic pin_in,
  output logic      level,
  output logic      rise,
  output logic      change
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_q <= 1'h0;
      sync_q <= 1'h0;
      prev_q <= 1'h0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level  = sync_q;
  assign rise   = sync_q & ~prev_q;
  assign change = sync_q ^ prev_q;

endmodule

// ==== src/cpmc_warmup.sv ====
// counter of oscillator edges for start-up and wakeup delays
`timescale 1ns/10ps
module cpmc_warmup (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic        tick,
  input  wire logic [11:0] target,
  output logic             busy,
  output logic             done
);

  logic [11:0] cnt_q;
  logic        busy_q;
  logic        last;

  assign last = (cnt_q == target - 12'h001);
  assign done = busy_q & tick & last;
  assign busy = busy_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy_q <= 1'h1;
      cnt_q  <= 12'h000;
    end else if (start) begin
      busy_q <= 1'h1;
      cnt_q  <= 12'h000;
    end else if (done) begin
      busy_q <= 1'h0;
      cnt_q  <= 12'h000;
    end else if (busy_q && tick) begin
      cnt_q <= cnt_q + 12'h001;
    end
  end

endmodule

// ==== test/cpmc_top_props.sv ====
// assertion checker for the clock and power mode control block
`timescale 1ns/10ps
module cpmc_top_props (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       wake_pin,
  input wire logic       timer0_run_enable,
  input wire logic       timer1_run_enable,
  input wire logic       hosc_enable,
  input wire logic       lrc_enable,
  input wire logic [1:0] xtal_drive,
  input wire logic       osc_out_gpio,
  input wire logic       sysclk_low_sel,
  input wire logic       cpu_cycle_en,
  input wire logic       cpu_exec_en,
  input wire logic       timer0_tick_en,
  input wire logic       timer1_tick_en,
  input wire logic       watchdog_run,
  input wire logic       watchdog_clk_en,
  input wire logic       irq_accept,
  input wire logic       reset_hold
);
  // **********
  // helpers
  // **********
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire asleep = !irq_accept && !hosc_enable && !reset_hold;

  // **********
  // properties
  // **********
  a_gpio_rc: assert property (osc_out_gpio == (xtal_drive == cpmc_pkg::CPMC_HCLK_RC))
    else $error("output pin gpio use does not follow rc type");
  a_lrc_stop: assert property (!lrc_enable |-> asleep || (xtal_drive == cpmc_pkg::CPMC_HCLK_32K && !watchdog_run))
    else $error("low rc stopped outside its two cases");
  a_sleep_quiet: assert property (asleep |-> !lrc_enable && !cpu_cycle_en && !timer0_tick_en && !timer1_tick_en)
    else $error("activity seen in power-down");
  a_sleep_hold: assert property (asleep && $past(wake_pin) == wake_pin && $past(wake_pin, 2) == wake_pin
    && $past(wake_pin, 3) == wake_pin && $past(wake_pin, 4) == wake_pin |=> !hosc_enable)
    else $error("power-down left without a wake pin change");
  a_slow_gap: assert property (cpu_cycle_en && sysclk_low_sel && $past(sysclk_low_sel)
    |=> (!cpu_cycle_en || !sysclk_low_sel) [*8])
    else $error("slow instruction cycles too close");
  a_exec_cycle: assert property (cpu_exec_en |-> cpu_cycle_en && irq_accept && !reset_hold)
    else $error("execution pulse without an instruction cycle");
  a_tick_gate: assert property (timer0_tick_en |-> cpu_cycle_en && timer0_run_enable)
    else $error("timer zero tick without cycle or enable");
  a_tick1_gate: assert property (timer1_tick_en |-> cpu_cycle_en && timer1_run_enable)
    else $error("timer one tick without cycle or enable");
  a_wdt_gate: assert property (watchdog_clk_en |-> watchdog_run)
    else $error("watchdog clocked while its option is off");
  a_boot_hold: assert property (reset_hold |-> !cpu_cycle_en && !irq_accept && hosc_enable)
    else $error("activity before oscillator start-up ended");
endmodule

bind cpmc_top cpmc_top_props i_props (.clk_sys, .rst, .wake_pin, .timer0_run_enable, .timer1_run_enable,
  .hosc_enable, .lrc_enable, .xtal_drive, .osc_out_gpio, .sysclk_low_sel, .cpu_cycle_en, .cpu_exec_en,
  .timer0_tick_en, .timer1_tick_en, .watchdog_run, .watchdog_clk_en, .irq_accept, .reset_hold);

// ==== test/cpmc_osc_model.sv ====
// oscillator model: high and low clock pins, standing still while stopped
`timescale 1ns/10ps
module cpmc_osc_model #(
  parameter int LRC_HALF = 4
) (
  input  wire logic clk_sys,
  input  wire logic hosc_enable,
  input  wire logic lrc_enable,
  output logic      hosc_clk_pin,
  output logic      lrc_clk_pin
);
  int lrc_cnt = 0;
  initial begin
    hosc_clk_pin = 1'b0;
    lrc_clk_pin  = 1'b0;
  end
  // high oscillator toggles every cycle only while enabled
  always @(posedge clk_sys) begin
    if (hosc_enable) hosc_clk_pin <= ~hosc_clk_pin;
  end
  // low rc toggles every LRC_HALF cycles only while enabled
  always @(posedge clk_sys) begin
    if (lrc_enable) begin
      lrc_cnt <= (lrc_cnt + 1) % LRC_HALF;
      if (lrc_cnt == LRC_HALF - 1) lrc_clk_pin <= ~lrc_clk_pin;
    end
  end
endmodule

// ==== test/tb_top.sv ====
// self-checking bench for the clock and power mode control block
`timescale 1ns/10ps
module tb_top;
  logic        clk_sys, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, wake_pin;
  logic        hosc_clk_pin, lrc_clk_pin, timer0_overflow, timer0_run_enable, timer1_run_enable;
  logic        hosc_enable, lrc_enable, osc_out_gpio, sysclk_low_sel, cpu_cycle_en, cpu_exec_en;
  logic        timer0_tick_en, timer1_tick_en, watchdog_run, watchdog_clk_en, irq_accept, reset_hold;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, xtal_drive;
  int          fails = 0, num_checks = 0, cycles = 0, n_cyc = 0, n_exec = 0, n_tk = 0, n_wd = 0;
  localparam logic [11:0] A_OSC = cpmc_pkg::CPMC_CTRL_ADDR;
  localparam logic [11:0] A_OPT = cpmc_pkg::CPMC_OPT_ADDR;
  localparam logic [11:0] A_ST  = cpmc_pkg::CPMC_STAT_ADDR;

  cpmc_top i_dut (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hosc_clk_pin, .lrc_clk_pin,
    .wake_pin, .timer0_overflow, .timer0_run_enable, .timer1_run_enable, .hosc_enable, .lrc_enable,
    .xtal_drive, .osc_out_gpio, .sysclk_low_sel, .cpu_cycle_en, .cpu_exec_en, .timer0_tick_en,
    .timer1_tick_en, .watchdog_run, .watchdog_clk_en, .irq_accept, .reset_hold);
  cpmc_osc_model i_osc (.clk_sys, .hosc_enable, .lrc_enable, .hosc_clk_pin, .lrc_clk_pin);

  // **********
  // clock, timeout and pulse counters
  // **********
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cpu_cycle_en === 1'b1) n_cyc++;
    if (cpu_exec_en === 1'b1) n_exec++;
    if (timer0_tick_en === 1'b1) n_tk++;
    if (watchdog_clk_en === 1'b1) n_wd++;
    if (cycles == 30000) begin
      fails++;
      give_verdict();
    end
  end

  // **********
  // compare and bus tasks
  // **********
  task give_verdict();
    if (fails == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    num_checks++;
    if (got < lo || got > hi) begin
      fails++;
      $display("ERROR %s expected %0d to %0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk_word("write response", 32'h0, {30'h0, r});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] mask, input string what);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk_word(what, exp, d & mask);
    chk_word("read response", 32'h0, {30'h0, r});
  endtask
  task automatic wait_exec(output int c);
    c = 0;
    do begin
      @(posedge clk_sys);
      c++;
    end while (cpu_exec_en !== 1'b1 && c < 9000);
  endtask
  task automatic pulse_ovf();
    @(posedge clk_sys);
    timer0_overflow <= 1'b1;
    @(posedge clk_sys);
    timer0_overflow <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask

  // **********
  // scenarios
  // **********
  task automatic t_boot();
    int          c;
    logic [31:0] d;
    logic [1:0]  r;
    chk_bit("reset hold", 1'b1, reset_hold);
    wait_exec(c);
    chk_rng("boot cycles", 4096, 4124, c);
    chk_bit("reset hold", 1'b0, reset_hold);
    rd(A_OSC, 32'h0, 32'hFF, "mode register reset");
    rd(A_OPT, 32'h6, 32'hFF, "option reset");
    rd(A_ST, 32'h31, 32'hF7, "status running");
    axi_rd(12'h7F0, d, r);
    chk_word("unmapped read response", 32'h2, {30'h0, r});
    chk_word("unmapped read data", 32'h0, d);
    axi_wr(12'h7F0, 32'h1F, r);
    chk_word("unmapped write response", 32'h2, {30'h0, r});
  endtask
  task automatic t_types();
    for (int t = 0; t < 4; t++) begin
      wr(A_OPT, 32'h4 | 32'(t));
      chk_word("crystal drive", 32'(t), {30'h0, xtal_drive});
      chk_bit("output pin gpio", t == 0, osc_out_gpio);
    end
    wr(A_OPT, 32'h6);
  endtask
  task automatic t_slow();
    int c0, w0;
    wr(A_OSC, 32'h4);
    chk_bit("low clock select", 1'b1, sysclk_low_sel);
    repeat (64) @(posedge clk_sys);
    c0 = n_cyc;
    w0 = n_wd;
    repeat (640) @(posedge clk_sys);
    chk_rng("slow cycles", 19, 21, n_cyc - c0);
    chk_rng("watchdog ticks", 79, 81, n_wd - w0);
    wr(A_OSC, 32'h6);
    chk_bit("high osc run", 1'b0, hosc_enable);
    chk_bit("low rc run", 1'b1, lrc_enable);
    wr(A_OSC, 32'h4);
    chk_bit("high osc run", 1'b1, hosc_enable);
    repeat (200) @(posedge clk_sys);
    wr(A_OSC, 32'h0);
    chk_bit("low clock select", 1'b0, sysclk_low_sel);
    c0 = n_cyc;
    repeat (64) @(posedge clk_sys);
    chk_rng("normal cycles", 31, 33, n_cyc - c0);
  endtask
  task automatic t_green();
    int e0;
    int k0;
    wr(A_OSC, 32'h4);
    timer1_run_enable <= 1'b1;
    wr(A_OSC, 32'h14);
    rd(A_ST, 32'h32, 32'hF7, "status green");
    timer0_run_enable <= 1'b1;
    e0 = n_exec;
    k0 = n_tk;
    repeat (200) @(posedge clk_sys);
    chk_rng("execution in green", 0, 0, n_exec - e0);
    chk_rng("timer ticks in green", 5, 7, n_tk - k0);
    timer0_run_enable <= 1'b0;
    pulse_ovf();
    rd(A_ST, 32'h2, 32'h07, "green kept");
    timer0_run_enable <= 1'b1;
    pulse_ovf();
    rd(A_OSC, 32'h4, 32'hFF, "mode after timer wake");
    wr(A_OSC, 32'h0);
    wr(A_OPT, 32'h1);
    chk_bit("watchdog run", 1'b0, watchdog_run);
    wr(A_OSC, 32'h10);
    chk_bit("low rc run", 1'b0, lrc_enable);
    chk_bit("irq accept", 1'b1, irq_accept);
    wake_pin <= ~wake_pin;
    repeat (6) @(posedge clk_sys);
    rd(A_OSC, 32'h0, 32'hFF, "mode after pin wake");
    chk_bit("low rc run", 1'b1, lrc_enable);
    wr(A_OPT, 32'h6);
  endtask
  task automatic t_sleep();
    int c;
    wr(A_OSC, 32'h4);
    wr(A_OSC, 32'hC);
    chk_bit("high osc run", 1'b0, hosc_enable);
    chk_bit("low rc run", 1'b0, lrc_enable);
    chk_bit("irq accept", 1'b0, irq_accept);
    chk_bit("watchdog run", 1'b1, watchdog_run);
    pulse_ovf();
    rd(A_ST, 32'h3, 32'h07, "power-down kept");
    @(posedge clk_sys);
    wake_pin <= ~wake_pin;
    wait_exec(c);
    chk_rng("wake cycles", 4096, 4124, c);
    rd(A_OSC, 32'h0, 32'hFF, "mode after power-down");
    wr(A_OSC, 32'h18);
    rd(A_ST, 32'h1, 32'h07, "reserved mode runs");
    wr(A_OSC, 32'h0);
  endtask

  initial begin
    rst               = 1'b1;
    s_axi_awaddr      = 12'h0;
    s_axi_awvalid     = 1'b0;
    s_axi_wdata       = 32'h0;
    s_axi_wstrb       = 4'hF;
    s_axi_wvalid      = 1'b0;
    s_axi_bready      = 1'b0;
    s_axi_araddr      = 12'h0;
    s_axi_arvalid     = 1'b0;
    s_axi_rready      = 1'b0;
    wake_pin          = 1'b0;
    timer0_overflow   = 1'b0;
    timer0_run_enable = 1'b0;
    timer1_run_enable = 1'b0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    t_boot();
    t_types();
    t_slow();
    t_green();
    t_sleep();
    give_verdict();
  end
endmodule
